// [inc/dsas_pkg.sv]
// Package: register map, field layout and timing constants of the dual converter sequencer
package dsas_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int RES_W  = 10;
  localparam int CH_W   = 3;
  localparam int NCH    = 8;

  // Register index map (word addresses on the plain register port)
  localparam logic [ADDR_W-1:0] A_MODE0   = 6'h00;
  localparam logic [ADDR_W-1:0] A_TIME0   = 6'h01;
  localparam logic [ADDR_W-1:0] A_DET0    = 6'h02;
  localparam logic [ADDR_W-1:0] A_MODE1   = 6'h04;
  localparam logic [ADDR_W-1:0] A_TIME1   = 6'h05;
  localparam logic [ADDR_W-1:0] A_DET1    = 6'h06;
  localparam logic [ADDR_W-1:0] A_TRGSEL  = 6'h08;
  localparam logic [ADDR_W-1:0] A_RES0    = 6'h10;
  localparam logic [ADDR_W-1:0] A_RES1    = 6'h18;
  localparam logic [ADDR_W-1:0] A_RES_MSK = 6'h38;

  // Byte lane strobes: bit 1 upper byte, bit 0 lower byte
  localparam logic [1:0] BE_HI = 2'h2;
  localparam logic [1:0] BE_LO = 2'h1;

  // Mode/scan register fields
  localparam int F_ENABLE    = 15;
  localparam int F_BUSY      = 14;
  localparam int F_POLL      = 13;
  localparam int F_TRG_LSB   = 10;
  localparam int F_SCAN      = 8;
  localparam int F_START_LSB = 4;
  localparam int F_END_LSB   = 0;
  localparam logic [15:0] MODE_WR_MASK = 16'hBDFF;
  localparam logic [2:0]  TRG_SOFT  = 3'h0;
  localparam logic [2:0]  TRG_TIMER = 3'h1;
  localparam logic [2:0]  TRG_EXT   = 3'h2;

  // Conversion time register: upper byte writable, lower byte read-only
  localparam logic [7:0]  TIME_HI_RESET = 8'h01;
  localparam int          F_TIME_LSB    = 8;

  // Voltage detect register fields
  localparam int F_DET_EN     = 15;
  localparam int F_DET_ABOVE  = 14;
  localparam int F_DET_CH_LSB = 10;
  localparam logic [15:0] DET_WR_MASK = 16'hDFFF;

  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] MODE_RESET = 16'h0000;
endpackage : dsas_pkg

// [logic/dsas_top.sv]
// Two-converter successive approximation sequencer with register port
// Notes on behaviour
// R1 - Mode/scan write during conversion aborts and restarts sequence from first step; restarts only in soft mode with enable set, else idle or standby
// R2 - Software clears enable before writing a different mode/scan value
// R3 - Software clears enable in a separate write before changing trigger mode
// R4 - Conversion-time write during conversion suspends then ends the conversion
// R5 - Conversion-time: upper byte read/write, lower byte read-only, whole word readable
// R6 - Voltage-detect write during conversion suspends then ends the conversion
// R7 - Result reads give ten bits low, upper six bits zero
// R8 - Result registers read-only; writes ignored
// R9 - Eight dedicated result registers per converter, sixteen total
// R10 - Finished ten-bit approximation stored in that channel's result register
// R11 - Termination interrupt once the specified conversions of the sequence finish
// R12 - Detect enabled: compare monitored result with reference, flag above or below
// R13 - Enable starts at once in soft trigger mode, polling or not, else enters trigger standby
// R14 - Same-value mode rewrite: interrupted conversion stores no result
// R15 - Each trigger in standby runs one sequence, then standby with enable set
// R16 - Soft-start mode clears active status and stops after termination
// R17 - Polling mode keeps active set and restarts until enable cleared
// R18 - Polling mode raises termination interrupt on every completion
// R19 - Timer trigger chosen by shared eight-bit source select register
// R20 - External trigger mode starts on converter's external trigger pin
// R21 - Select mode converts only the chosen channel into its own register
// R22 - Scan mode converts start through end channel, interrupt after end
// R23 - Software keeps scan start channel below scan end channel
// R24 - Active status reads one while sequence runs or repeats, zero when stopped
module dsas_top #(
  parameter int NCONV = 2
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic [dsas_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [dsas_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic [1:0]                  reg_byte_en,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [dsas_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [7:0]                  timer_events,
  input  wire logic [NCONV-1:0]            external_trigger_pin,
  output logic      [NCONV-1:0]            sample_start,
  output logic      [NCONV*3-1:0]          analog_input_channel,
  output logic      [NCONV-1:0]            comparator_trial_bit,
  input  wire logic [NCONV-1:0]            comparator_above,
  output logic      [NCONV-1:0]            conversion_done_irq,
  output logic      [NCONV-1:0]            voltage_detect_irq
);
  // The register map and the shared select byte have room for two converters only
  if (NCONV != 2) begin : g_bad_nconv
    $error("dsas_top serves exactly two converters");
  end

  // Field geometry used below
  localparam int TRG_W     = 3;
  localparam int TSEL_W    = 3;
  localparam int TSEL_STEP = 4;
  localparam int DET_REF_W = dsas_pkg::RES_W;

  // Software-written shared timer source select: 4 bits per converter
  logic [7:0]       timer_trigger_source_select;
  // Pin synchronisers and edge history; ext_sync and ext_prev feed logic
  logic [NCONV-1:0] ext_meta;
  logic [NCONV-1:0] ext_sync;
  logic [NCONV-1:0] ext_prev;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ext_meta <= '0;
      ext_sync <= '0;
      ext_prev <= '0;
    end else begin
      ext_meta <= external_trigger_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      timer_trigger_source_select <= 8'h00;
    end else if (reg_write && reg_addr == dsas_pkg::A_TRGSEL && reg_byte_en[0]) begin
      timer_trigger_source_select <= reg_wdata[7:0]; // [R19]
    end
  end

  logic [15:0] rd_mux [NCONV];

  for (genvar g = 0; g < NCONV; g++) begin : g_conv
    typedef enum logic [1:0] {DSAS_IDLE, DSAS_STANDBY, DSAS_CONVERT} dsas_state_t;
    dsas_state_t state;
    logic [15:0] mode_scan_control;
    logic [7:0]  conv_time_hi;
    logic [15:0] voltage_detect_control;
    logic [9:0]  result [dsas_pkg::NCH];
    logic [9:0]  sar;
    logic [3:0]  bit_idx;
    logic [7:0]  slot_cnt;
    logic [2:0]  cur_ch;
    logic        busy;
    logic [5:0]  base;
    logic        wr_mode;
    logic        wr_time;
    logic        wr_det;
    logic        wr_abort;
    logic        trig_evt;
    logic        timer_evt;
    logic        ext_evt;
    logic        last_ch;
    logic        done_pulse;
    logic        det_pulse;
    logic [15:0] next_mode_scan;
    logic [2:0]  trg;
    logic [2:0]  start_ch;
    logic [2:0]  end_ch;

    assign base     = (g == 0) ? dsas_pkg::A_MODE0 : dsas_pkg::A_MODE1;
    assign wr_mode  = reg_write && reg_addr == base;
    assign wr_time  = reg_write && reg_addr == (base | dsas_pkg::A_TIME0);
    assign wr_det   = reg_write && reg_addr == (base | dsas_pkg::A_DET0);
    // Any of these writes cuts the running channel short, so nothing may be stored
    assign wr_abort = wr_mode || wr_time || wr_det;
    assign trg      = mode_scan_control[dsas_pkg::F_TRG_LSB +: TRG_W];
    assign start_ch = mode_scan_control[dsas_pkg::F_START_LSB +: dsas_pkg::CH_W];
    assign end_ch   = mode_scan_control[dsas_pkg::F_END_LSB +: dsas_pkg::CH_W];
    // Timer events count as levels: one held high also starts the next sequence
    assign timer_evt = timer_events[timer_trigger_source_select[g*TSEL_STEP +: TSEL_W]]; // [R19]
    // Pin edges outside standby are dropped, not queued
    assign ext_evt  = ext_sync[g] && !ext_prev[g]; // [R20]
    assign trig_evt = (trg == dsas_pkg::TRG_TIMER) ? timer_evt :
                      (trg == dsas_pkg::TRG_EXT) ? ext_evt : 1'b0;
    assign last_ch  = !mode_scan_control[dsas_pkg::F_SCAN] || cur_ch == end_ch; // [R21] [R22]
    assign busy     = state == DSAS_CONVERT
                      || (state != DSAS_IDLE && mode_scan_control[dsas_pkg::F_POLL]);
    wire logic first_ch_sel = mode_scan_control[dsas_pkg::F_SCAN] ? 1'b1 : 1'b0;
    wire logic [2:0] first_ch = first_ch_sel ? start_ch
                                : mode_scan_control[dsas_pkg::F_START_LSB +: 3];
    wire logic soft_mode = trg == dsas_pkg::TRG_SOFT;
    wire logic slot_end = slot_cnt == 8'h00;
    wire logic step_done = slot_end && bit_idx == 4'h0;

    // Value a mode write leaves behind; a one-lane write keeps the other lane
    always_comb begin
      next_mode_scan = mode_scan_control;
      if (reg_byte_en[1])
        next_mode_scan[15:8] = reg_wdata[15:8] & dsas_pkg::MODE_WR_MASK[15:8];
      if (reg_byte_en[0])
        next_mode_scan[7:0] = reg_wdata[7:0];
    end

    // Register storage and effects of writes
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        mode_scan_control      <= dsas_pkg::MODE_RESET;
        conv_time_hi           <= dsas_pkg::TIME_HI_RESET;
        voltage_detect_control <= dsas_pkg::ZERO16;
      end else begin
        if (wr_mode) begin
          mode_scan_control <= next_mode_scan;
        end else if (state == DSAS_CONVERT && step_done && last_ch && soft_mode
                     && !wr_abort && !mode_scan_control[dsas_pkg::F_POLL]) begin
          mode_scan_control[dsas_pkg::F_ENABLE] <= 1'b0; // [R16]
        end
        if (wr_time && reg_byte_en[1])
          conv_time_hi <= reg_wdata[15:8]; // [R5]
        if (wr_det) begin
          if (reg_byte_en[1])
            voltage_detect_control[15:8] <= reg_wdata[15:8] & dsas_pkg::DET_WR_MASK[15:8];
          if (reg_byte_en[0])
            voltage_detect_control[7:0] <= reg_wdata[7:0];
        end
      end
    end

    // Sequencer state machine with SAR stepping
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        state    <= DSAS_IDLE;
        sar      <= 10'h000;
        bit_idx  <= 4'h0;
        slot_cnt <= 8'h00;
        cur_ch   <= 3'h0;
      end else if (wr_time || wr_det) begin
        // Suspend, then end; enable stays set until software rewrites the mode
        state <= DSAS_IDLE; // [R4] [R6]
      end else if (wr_mode) begin
        // Abort; go idle if enable is cleared, else restart from first step in soft trigger mode or wait in standby in other trigger modes
        sar      <= 10'h000; // [R1] [R14]
        bit_idx  <= 4'(dsas_pkg::RES_W);
        slot_cnt <= conv_time_hi;
        cur_ch   <= next_mode_scan[dsas_pkg::F_START_LSB +: dsas_pkg::CH_W];
        if (!next_mode_scan[dsas_pkg::F_ENABLE])
          state <= DSAS_IDLE;
        else if (next_mode_scan[dsas_pkg::F_TRG_LSB +: TRG_W] == dsas_pkg::TRG_SOFT)
          state <= DSAS_CONVERT; // [R13]
        else
          state <= DSAS_STANDBY; // [R13]
      end else begin
        case (state)
          DSAS_IDLE: begin
          end
          DSAS_STANDBY: begin
            if (trig_evt) begin
              state    <= DSAS_CONVERT; // [R15]
              sar      <= 10'h000;
              bit_idx  <= 4'(dsas_pkg::RES_W);
              slot_cnt <= conv_time_hi;
              cur_ch   <= first_ch;
            end
          end
          DSAS_CONVERT: begin
            if (!slot_end) begin
              slot_cnt <= slot_cnt - 8'h01;
            end else if (bit_idx != 4'h0) begin
              sar[bit_idx - 4'h1] <= comparator_above[g];
              bit_idx  <= bit_idx - 4'h1;
              slot_cnt <= conv_time_hi;
            end else begin
              sar      <= 10'h000;
              bit_idx  <= 4'(dsas_pkg::RES_W);
              slot_cnt <= conv_time_hi;
              if (!last_ch) begin
                cur_ch <= cur_ch + 3'h1; // [R22]
              end else begin
                cur_ch <= first_ch;
                if (mode_scan_control[dsas_pkg::F_POLL])
                  state <= DSAS_CONVERT; // [R17]
                else if (soft_mode)
                  state <= DSAS_IDLE; // [R16]
                else
                  state <= DSAS_STANDBY; // [R15]
              end
            end
          end
          default: state <= DSAS_IDLE;
        endcase
      end
    end

    // Result storage, detection and interrupt pulses
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        for (int i = 0; i < dsas_pkg::NCH; i++) result[i] <= 10'h000;
        done_pulse <= 1'b0;
        det_pulse  <= 1'b0;
      end else begin
        done_pulse <= 1'b0;
        det_pulse  <= 1'b0;
        // In polling mode an unread result is simply overwritten
        if (state == DSAS_CONVERT && step_done && !wr_abort) begin
          result[cur_ch] <= sar; // [R9] [R10] [R14]
          if (last_ch)
            done_pulse <= 1'b1; // [R11] [R18]
          if (voltage_detect_control[dsas_pkg::F_DET_EN]
              && cur_ch == voltage_detect_control[dsas_pkg::F_DET_CH_LSB +: dsas_pkg::CH_W]) begin
            if (voltage_detect_control[dsas_pkg::F_DET_ABOVE])
              det_pulse <= sar >= voltage_detect_control[DET_REF_W-1:0]; // [R12]
            else
              det_pulse <= sar < voltage_detect_control[DET_REF_W-1:0]; // [R12]
          end
        end
      end
    end

    always_comb begin
      rd_mux[g] = dsas_pkg::ZERO16;
      if (reg_addr == base)
        rd_mux[g] = {mode_scan_control[15], busy, mode_scan_control[13:0]}; // [R24]
      else if (reg_addr == (base | dsas_pkg::A_TIME0))
        rd_mux[g] = {conv_time_hi, 8'h00}; // [R5]
      else if (reg_addr == (base | dsas_pkg::A_DET0))
        rd_mux[g] = voltage_detect_control;
      else if ((reg_addr & dsas_pkg::A_RES_MSK) == (g == 0 ? dsas_pkg::A_RES0 : dsas_pkg::A_RES1))
        rd_mux[g] = {6'h00, result[reg_addr[2:0]]}; // [R7] [R8]
    end

    assign sample_start[g] = state == DSAS_CONVERT && bit_idx == 4'(dsas_pkg::RES_W)
                             && slot_cnt == conv_time_hi;
    assign analog_input_channel[g*3 +: 3] = cur_ch;
    assign comparator_trial_bit[g] = state == DSAS_CONVERT;
    // One writer per pulse register; the output bit only follows it
    assign conversion_done_irq[g] = done_pulse;
    assign voltage_detect_irq[g]  = det_pulse;
  end

  // Unselected converters answer zero, so their read paths may simply be ORed
  logic [15:0] rd_any;
  always_comb begin
    rd_any = dsas_pkg::ZERO16;
    for (int k = 0; k < NCONV; k++)
      rd_any = rd_any | rd_mux[k];
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= dsas_pkg::ZERO16;
    end else if (reg_read) begin
      if (reg_addr == dsas_pkg::A_TRGSEL)
        reg_rdata <= {8'h00, timer_trigger_source_select};
      else
        reg_rdata <= rd_any;
    end else begin
      reg_rdata <= dsas_pkg::ZERO16;
    end
  end
endmodule : dsas_top

// [test/dsas_afe_model.sv]
// Analog front end model: a fixed level per channel, noise while idle
module dsas_afe_model (
  input  wire logic       sys_clk,
  input  wire logic [5:0] analog_input_channel,
  input  wire logic [1:0] comparator_trial_bit,
  output logic      [1:0] comparator_above
);
  timeunit 1ns;
  timeprecision 1ns;
  logic noise = 1'b0;
  always @(posedge sys_clk) noise <= ~noise;
  // Level fixed per channel, so the order of bit trials cannot matter
  // Idle comparator toggles so a stale sample is never mistaken for data
  assign comparator_above[0] = comparator_trial_bit[0] ? analog_input_channel[0] : noise;
  assign comparator_above[1] = comparator_trial_bit[1] ? ~analog_input_channel[3] : noise;
endmodule : dsas_afe_model

// [test/dsas_checker.sv]
// Concurrent checks on the sequencer's ports
module dsas_checker #(
  parameter int NCONV = 2
) (
  input wire logic                        sys_clk,
  input wire logic                        reset,
  input wire logic [dsas_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dsas_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [1:0]                  reg_byte_en,
  input wire logic                        reg_write,
  input wire logic                        reg_read,
  input wire logic [dsas_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [NCONV-1:0]            sample_start,
  input wire logic [NCONV*3-1:0]          analog_input_channel,
  input wire logic [NCONV-1:0]            comparator_trial_bit,
  input wire logic [NCONV-1:0]            conversion_done_irq,
  input wire logic [NCONV-1:0]            voltage_detect_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_result_upper_zero: assert property ($past(reg_read) && $past(reg_addr[5:4]) == 2'h1
    |-> reg_rdata[15:10] == 6'h00) else $error("result upper bits not zero");
  a_unmapped_zero: assert property ($past(reg_read) && $past(reg_addr) == 6'h03
    |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_done_one_cycle: assert property (conversion_done_irq[0] |=> !conversion_done_irq[0])
    else $error("done pulse longer than one cycle");
  a_det_one_cycle: assert property (voltage_detect_irq[0] |=> !voltage_detect_irq[0])
    else $error("detect pulse longer than one cycle");
  a_start_in_conv: assert property (sample_start[0] |-> comparator_trial_bit[0])
    else $error("start pulse outside conversion");
  a_start_chan_hold: assert property (sample_start[0] |=> $stable(analog_input_channel[2:0])
    && !sample_start[0]) else $error("channel moved right after start");
  a_time_wr_ends: assert property (reg_write && reg_addr == dsas_pkg::A_TIME0
    |-> ##[1:3] !comparator_trial_bit[0]) else $error("time write did not end conversion");
  a_det_wr_ends: assert property (reg_write && reg_addr == dsas_pkg::A_DET0
    |-> ##[1:3] !comparator_trial_bit[0]) else $error("detect write did not end conversion");
  a_mode_restarts: assert property (reg_write && reg_addr == dsas_pkg::A_MODE0
    && reg_byte_en == 2'h3 && reg_wdata[15] && reg_wdata[13:10] == 4'h0
    |-> ##[1:4] sample_start[0]) else $error("soft enable did not start");
endmodule : dsas_checker

bind dsas_top dsas_checker #(.NCONV(NCONV)) i_chk (.sys_clk(sys_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_byte_en(reg_byte_en),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .sample_start(sample_start), .analog_input_channel(analog_input_channel),
  .comparator_trial_bit(comparator_trial_bit), .conversion_done_irq(conversion_done_irq),
  .voltage_detect_irq(voltage_detect_irq));

// [test/dsas_tb.sv]
// Self-checking bench for the dual converter sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [1:0] reg_byte_en = 2'h3, ext_pin = 2'h0, smp, trial, above, done_irq, det_irq;
  logic [7:0] tmr = 8'h00;
  logic [5:0] chan;
  int n_fail = 0, num_checks = 0;
  always #50 sys_clk = ~sys_clk;
  dsas_top #(.NCONV(2)) i_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_byte_en(reg_byte_en), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_events(tmr),
    .external_trigger_pin(ext_pin), .sample_start(smp), .analog_input_channel(chan),
    .comparator_trial_bit(trial), .comparator_above(above),
    .conversion_done_irq(done_irq), .voltage_detect_irq(det_irq));
  dsas_afe_model i_afe (.sys_clk(sys_clk), .analog_input_channel(chan),
    .comparator_trial_bit(trial), .comparator_above(above));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge sys_clk);
    reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d; reg_byte_en <= be;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_read <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd_chk
  // Waits a bounded time for an interrupt pulse; hit reports whether it came
  task automatic wait_irq(input int c, input bit det, output bit hit);
    hit = 1'b0;
    repeat (150) begin
      @(posedge sys_clk);
      #1 if ((det ? det_irq[c] : done_irq[c]) === 1'b1) begin hit = 1'b1; break; end
    end
  endtask : wait_irq
  task automatic t_regs;
    for (int a = 0; a < 4; a++) rd_chk(6'(a), a == 1 ? 16'h0100 : 16'h0000);
    wr(dsas_pkg::A_TIME0, 16'h03AA, 2'h1);
    rd_chk(dsas_pkg::A_TIME0, 16'h0100);
    $display("regs done");
  endtask : t_regs
  task automatic t_soft_scan;
    bit h;
    wr(dsas_pkg::A_MODE0, 16'h8030, 2'h3);
    wait_irq(0, 0, h); chk(16'(h), 16'h0001);
    rd_chk(dsas_pkg::A_MODE0, 16'h0030);
    rd_chk(6'h13, 16'h03FF); rd_chk(6'h12, 16'h0000);
    wr(6'h13, 16'h0000, 2'h3); rd_chk(6'h13, 16'h03FF);
    wr(dsas_pkg::A_MODE1, 16'h8114, 2'h3);
    wait_irq(1, 0, h); chk(16'(h), 16'h0001);
    for (int c = 0; c < 8; c++) rd_chk(6'(6'h18 + c), (c >= 1 && c <= 4 && c % 2 == 0)
      ? 16'h03FF : 16'h0000);
    $display("soft and scan done");
  endtask : t_soft_scan
  task automatic t_poll;
    bit h;
    wr(dsas_pkg::A_MODE0, 16'hA050, 2'h3);
    repeat (2) begin wait_irq(0, 0, h); chk(16'(h), 16'h0001); end
    rd_chk(dsas_pkg::A_MODE0, 16'hE050); rd_chk(6'h15, 16'h03FF);
    wr(dsas_pkg::A_MODE0, 16'h2050, 2'h3);
    repeat (4) @(posedge sys_clk);
    rd_chk(dsas_pkg::A_MODE0, 16'h2050);
    $display("poll done");
  endtask : t_poll
  task automatic t_triggers;
    bit h;
    wr(dsas_pkg::A_TRGSEL, 16'h0002, 2'h1); rd_chk(dsas_pkg::A_TRGSEL, 16'h0002);
    wr(dsas_pkg::A_MODE0, 16'h0410, 2'h3); wr(dsas_pkg::A_MODE0, 16'h8410, 2'h3);
    @(posedge sys_clk) tmr <= 8'h20;
    @(posedge sys_clk) tmr <= 8'h00;
    wait_irq(0, 0, h); chk(16'(h), 16'h0000);
    @(posedge sys_clk) tmr <= 8'h04;
    @(posedge sys_clk) tmr <= 8'h00;
    wait_irq(0, 0, h); chk(16'(h), 16'h0001);
    rd_chk(dsas_pkg::A_MODE0, 16'h8410);
    wr(dsas_pkg::A_MODE0, 16'h0410, 2'h3); wr(dsas_pkg::A_MODE1, 16'h0860, 2'h3);
    wr(dsas_pkg::A_MODE1, 16'h8860, 2'h3);
    @(posedge sys_clk) ext_pin <= 2'h1;
    wait_irq(1, 0, h); chk(16'(h), 16'h0000);
    @(posedge sys_clk) ext_pin <= 2'h2;
    wait_irq(1, 0, h); chk(16'(h), 16'h0001); rd_chk(6'h1E, 16'h03FF);
    @(posedge sys_clk) ext_pin <= 2'h0;
    wr(dsas_pkg::A_MODE1, 16'h0860, 2'h3);
    $display("triggers done");
  endtask : t_triggers
  task automatic t_abort_detect;
    bit h;
    wr(dsas_pkg::A_MODE0, 16'h0070, 2'h3); wr(dsas_pkg::A_MODE0, 16'h8070, 2'h3);
    repeat (5) @(posedge sys_clk);
    wr(dsas_pkg::A_TIME0, 16'h0100, 2'h3);
    wait_irq(0, 0, h); chk(16'(h), 16'h0000); rd_chk(6'h17, 16'h0000);
    wr(dsas_pkg::A_MODE0, 16'h8070, 2'h3);
    // Rewrite lands on the edge that would store the first result
    repeat (20) @(posedge sys_clk);
    wr(dsas_pkg::A_MODE0, 16'h8070, 2'h3);
    rd_chk(6'h17, 16'h0000);
    wait_irq(0, 0, h); chk(16'(h), 16'h0001); rd_chk(6'h17, 16'h03FF);
    wr(dsas_pkg::A_DET0, 16'hC500, 2'h3); wr(dsas_pkg::A_MODE0, 16'h8010, 2'h3);
    wait_irq(0, 1, h); chk(16'(h), 16'h0001);
    wr(dsas_pkg::A_DET0, 16'h8500, 2'h3); wr(dsas_pkg::A_MODE0, 16'h8010, 2'h3);
    wait_irq(0, 1, h); chk(16'(h), 16'h0000);
    wr(dsas_pkg::A_DET1, 16'h8500, 2'h3); wr(dsas_pkg::A_MODE1, 16'h8010, 2'h3);
    wait_irq(1, 1, h); chk(16'(h), 16'h0001);
    $display("abort and detect done");
  endtask : t_abort_detect
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_soft_scan();
    t_poll();
    t_triggers();
    t_abort_detect();
    end_sim();
  end
  initial begin
    #3000000;
    n_fail++;
    end_sim();
  end
endmodule : tb
